// file: bench/fcr_core_assertions.sv
// Concurrent checks on the clear, retransmit and mode ports
`timescale 1ns/100ps
`default_nettype none
`include "fcr_defines.svh"

module fcr_core_assertions (
  // Clock and reset
  input wire logic                   I_MCLK,
  input wire logic                   I_RST_B,
  // Observed inputs
  input wire logic                   I_FULL_CLEAR_B,
  input wire logic                   I_PARTIAL_CLEAR_B,
  input wire logic                   I_MODE_SELECT_SERIAL_IN,
  input wire logic                   I_FLAG_TIMING_SELECT,
  input wire logic                   I_RETRANSMIT_LATENCY_SELECT,
  input wire logic                   I_READ_PORT_WIDTH,
  input wire logic                   I_REREAD_REQUEST_B,
  // Observed outputs
  input wire logic [`FCR_WORD_W-1:0] O_READ_DATA_OUT,
  input wire logic                   O_EMPTY_FLAG_OR_B,
  input wire logic                   O_FULL_FLAG_IR_B,
  input wire logic                   O_ALMOST_EMPTY_FLAG_B,
  input wire logic                   O_ALMOST_FULL_FLAG_B,
  input wire logic                   O_HALF_FULL_FLAG_B,
  input wire logic                   O_FALL_THROUGH_MODE,
  input wire logic                   O_SYNC_FLAG_TIMING,
  input wire logic                   O_ZERO_LATENCY,
  input wire logic                   O_READ_WIDTH_NARROW
);
  logic [3:0] cfg;

  assign cfg = {O_FALL_THROUGH_MODE, O_SYNC_FLAG_TIMING, O_ZERO_LATENCY, O_READ_WIDTH_NARROW};

  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RST_B);

  // ********************************
  // Sequences
  // ********************************
  sequence std_clear_s;
    (!I_FULL_CLEAR_B && !I_MODE_SELECT_SERIAL_IN) [*4];
  endsequence
  sequence ft_clear_s;
    (!I_FULL_CLEAR_B && I_MODE_SELECT_SERIAL_IN) [*4];
  endsequence
  // Release is two edges late, so five quiet edges leave room for it
  sequence quiet_s;
    (I_FULL_CLEAR_B && I_RST_B) [*5];
  endsequence

  // ********************************
  // Assertions
  // ********************************
  full_data_a: assert property (!I_FULL_CLEAR_B |-> O_READ_DATA_OUT == `FCR_DATA_RST)
    else $error("data out not zero in full clear");
  full_flags_a: assert property (!I_FULL_CLEAR_B |->
    (!O_ALMOST_EMPTY_FLAG_B && O_ALMOST_FULL_FLAG_B && O_HALF_FULL_FLAG_B))
    else $error("flag levels wrong in full clear");
  part_clear_a: assert property (!I_PARTIAL_CLEAR_B |-> (O_READ_DATA_OUT == `FCR_DATA_RST &&
    !O_ALMOST_EMPTY_FLAG_B && O_ALMOST_FULL_FLAG_B && O_HALF_FULL_FLAG_B))
    else $error("partial clear outputs wrong");
  std_mode_a: assert property (std_clear_s |-> (!O_EMPTY_FLAG_OR_B && O_FULL_FLAG_IR_B))
    else $error("standard flags wrong in clear");
  ft_mode_a: assert property (ft_clear_s |-> (O_EMPTY_FLAG_OR_B && !O_FULL_FLAG_IR_B))
    else $error("fall-through flags wrong in clear");
  cfg_latch_a: assert property ((!I_FULL_CLEAR_B) [*4] |->
    (O_SYNC_FLAG_TIMING == $past(I_FLAG_TIMING_SELECT, 3)
     && O_ZERO_LATENCY == !$past(I_RETRANSMIT_LATENCY_SELECT, 3)
     && O_READ_WIDTH_NARROW == $past(I_READ_PORT_WIDTH, 3)))
    else $error("configuration not latched in clear");
  cfg_hold_a: assert property (quiet_s |-> $stable(cfg))
    else $error("configuration changed outside full clear");
  narrow_out_a: assert property (O_READ_WIDTH_NARROW |-> O_READ_DATA_OUT[17:9] == 9'h000)
    else $error("upper data bits driven in narrow mode");
  reread_setup_a: assert property ((!I_REREAD_REQUEST_B && !O_ZERO_LATENCY && I_FULL_CLEAR_B &&
    I_PARTIAL_CLEAR_B) |=> O_EMPTY_FLAG_OR_B == O_FALL_THROUGH_MODE)
    else $error("reread setup flag wrong");
  clear_release_a: assert property ($rose(I_PARTIAL_CLEAR_B) |->
    (O_READ_DATA_OUT == `FCR_DATA_RST && !O_ALMOST_EMPTY_FLAG_B))
    else $error("partial clear released early");
endmodule

bind fcr_core fcr_core_assertions u_chk (
  .I_MCLK(I_MCLK), .I_RST_B(I_RST_B), .I_FULL_CLEAR_B(I_FULL_CLEAR_B), .I_PARTIAL_CLEAR_B(I_PARTIAL_CLEAR_B),
  .I_MODE_SELECT_SERIAL_IN(I_MODE_SELECT_SERIAL_IN), .I_FLAG_TIMING_SELECT(I_FLAG_TIMING_SELECT),
  .I_RETRANSMIT_LATENCY_SELECT(I_RETRANSMIT_LATENCY_SELECT), .I_READ_PORT_WIDTH(I_READ_PORT_WIDTH),
  .I_REREAD_REQUEST_B(I_REREAD_REQUEST_B), .O_READ_DATA_OUT(O_READ_DATA_OUT),
  .O_EMPTY_FLAG_OR_B(O_EMPTY_FLAG_OR_B), .O_FULL_FLAG_IR_B(O_FULL_FLAG_IR_B),
  .O_ALMOST_EMPTY_FLAG_B(O_ALMOST_EMPTY_FLAG_B), .O_ALMOST_FULL_FLAG_B(O_ALMOST_FULL_FLAG_B),
  .O_HALF_FULL_FLAG_B(O_HALF_FULL_FLAG_B), .O_FALL_THROUGH_MODE(O_FALL_THROUGH_MODE),
  .O_SYNC_FLAG_TIMING(O_SYNC_FLAG_TIMING), .O_ZERO_LATENCY(O_ZERO_LATENCY),
  .O_READ_WIDTH_NARROW(O_READ_WIDTH_NARROW));
`default_nettype wire

// file: bench/fcr_core_tb_top.sv
// Self-checking bench for the clear, retransmit and mode control
`timescale 1ns/100ps
`default_nettype none
`include "fcr_defines.svh"

module fcr_core_tb_top;
  logic                   clk, rst_b, fc_b, pc_b, mode, fts, rm, rw, ww, bo, pi, acc_b, sen_b;
  logic                   wr_go, rd_go, rt_go, wen_b, ren_b, rt_b;
  logic [`FCR_WORD_W-1:0] wr_word, wdata, dout;
  logic                   ef_or, ff_ir, ae, af, hf, ft, ser, sft, zl, rn, wn, bo_o, pi_o;
  int                     errors, n_checks;

  fcr_peer u_peer (.i_clk(clk), .i_wr_go(wr_go), .i_wr_word(wr_word), .i_rd_go(rd_go), .i_rt_go(rt_go),
    .o_write_en_b(wen_b), .o_write_data(wdata), .o_read_en_b(ren_b), .o_reread_b(rt_b));

  fcr_core dut (.I_MCLK(clk), .I_RST_B(rst_b), .I_FULL_CLEAR_B(fc_b), .I_PARTIAL_CLEAR_B(pc_b),
    .I_MODE_SELECT_SERIAL_IN(mode), .I_FLAG_TIMING_SELECT(fts), .I_RETRANSMIT_LATENCY_SELECT(rm),
    .I_READ_PORT_WIDTH(rw), .I_WRITE_PORT_WIDTH(ww), .I_BYTE_ORDER_SELECT(bo),
    .I_PARITY_INTERLEAVE_SELECT(pi), .I_OFFSET_ACCESS_ENABLE_B(acc_b), .I_WRITE_EN_B(wen_b),
    .I_WRITE_DATA(wdata), .I_SERIAL_LOAD_ENABLE_B(sen_b), .I_READ_EN_B(ren_b), .I_REREAD_REQUEST_B(rt_b),
    .O_READ_DATA_OUT(dout), .O_EMPTY_FLAG_OR_B(ef_or), .O_FULL_FLAG_IR_B(ff_ir),
    .O_ALMOST_EMPTY_FLAG_B(ae), .O_ALMOST_FULL_FLAG_B(af), .O_HALF_FULL_FLAG_B(hf),
    .O_FALL_THROUGH_MODE(ft), .O_SERIAL_PROGRAM(ser), .O_SYNC_FLAG_TIMING(sft), .O_ZERO_LATENCY(zl),
    .O_READ_WIDTH_NARROW(rn), .O_WRITE_WIDTH_NARROW(wn), .O_BYTE_ORDER(bo_o), .O_PARITY_INTERLEAVE(pi_o));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ********************************
  // Shared tasks
  // ********************************
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Timing, latency, width, order and parity inputs are inverted on release so a late latch shows up
  task automatic full_clear(input logic m, input logic f, input logic r, input logic w, input logic s);
    @(posedge clk);
    {mode, fts, rm, rw, ww, bo, pi, acc_b} <= {m, f, r, w, w, f, r, s};
    fc_b <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk(dout, `FCR_DATA_RST);
    chk(18'({ae, af, hf}), 18'h0_0003);
    chk(18'({ef_or, ff_ir}), m ? 18'h0_0002 : 18'h0_0001);
    @(posedge clk);
    {fc_b, mode, fts, rm, rw, ww, bo, pi, acc_b} <= {2'b10, ~f, ~r, ~w, ~w, ~f, ~r, 1'b1};
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(18'({ft, ser, sft, zl, rn, wn, bo_o, pi_o}), 18'({m, s, f, ~r, w, w, f, r}));
  endtask

  task automatic wr_words(input int n, input logic [17:0] base);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      wr_go <= 1'b1;
      wr_word <= base + 18'(i);
    end
    @(posedge clk);
    wr_go <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic rd;
    @(posedge clk);
    rd_go <= 1'b1;
    @(posedge clk);
    rd_go <= 1'b0;
    @(negedge clk);
  endtask

  task automatic reread;
    @(posedge clk);
    rt_go <= 1'b1;
    @(posedge clk);
    rt_go <= 1'b0;
    @(negedge clk);
  endtask

  task automatic rd_offsets(input logic [6:0] e, input logic [6:0] f);
    @(posedge clk);
    acc_b <= 1'b0;
    rd_go <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk(dout, 18'(e));
    @(posedge clk);
    rd_go <= 1'b0;
    acc_b <= 1'b1;
    @(negedge clk);
    chk(dout, 18'(f));
  endtask

  // ********************************
  // Scenarios
  // ********************************
  task automatic s_width;
    full_clear(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    wr_words(1, 18'h3_A5C5);
    rd;
    chk(dout, 18'h0_01C5);
    full_clear(1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
    wr_words(1, 18'h3_A5C5);
    rd;
    chk(dout, 18'h3_A5C5);
  endtask

  task automatic s_reread_std;
    full_clear(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    wr_words(3, 18'h0_1110);
    rd;
    rd;
    chk(dout, 18'h0_1111);
    reread;
    chk(18'(ef_or), 18'h0_0000);
    repeat (2) @(posedge clk);
    rd;
    chk(dout, 18'h0_1110);
  endtask

  task automatic s_zero_ft;
    full_clear(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    wr_words(2, 18'h0_2220);
    chk(18'(ef_or), 18'h0_0000);
    chk(dout, 18'h0_2220);
    rd;
    chk(dout, 18'h0_2221);
    reread;
    chk(dout, 18'h0_2220);
    rd;
    chk(dout, 18'h0_2221);
  endtask

  // Runs on the fall-through state left by s_zero_ft
  task automatic s_partial;
    @(posedge clk);
    pc_b <= 1'b0;
    @(negedge clk);
    chk(dout, `FCR_DATA_RST);
    chk(18'({ef_or, ff_ir, ae, af, hf}), 18'h0_0013);
    repeat (3) @(posedge clk);
    pc_b <= 1'b1;
    repeat (3) @(posedge clk);
    wr_words(1, 18'h0_3330);
    chk(dout, 18'h0_3330);
    chk(18'({ft, ser, sft, zl, rn, wn, bo_o, pi_o}), 18'h0_00F2);
  endtask

  task automatic s_offset(input logic s);
    logic [13:0] pat = {7'h2A, 7'h15};
    full_clear(1'b0, 1'b0, 1'b1, 1'b0, s);
    rd_offsets(`FCR_EMPTY_OFF_RST, `FCR_FULL_OFF_RST);
    if (s) begin
      for (int i = 13; i >= 0; i--) begin
        @(posedge clk);
        sen_b <= 1'b0;
        mode <= pat[i];
      end
      @(posedge clk);
      sen_b <= 1'b1;
    end else begin
      @(posedge clk);
      acc_b <= 1'b0;
      wr_go <= 1'b1;
      wr_word <= 18'h0_0015;
      @(posedge clk);
      wr_word <= 18'h0_002A;
      @(posedge clk);
      wr_go <= 1'b0;
      acc_b <= 1'b1;
    end
    rd_offsets(7'h15, 7'h2A);
  endtask

  initial begin
    {rst_b, fc_b, pc_b, mode, fts, rm, rw, ww, bo, pi, acc_b, sen_b} = 12'h603;
    {wr_go, rd_go, rt_go} = 3'h0;
    wr_word = 18'h0_0000;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    s_width();
    s_reread_std();
    s_zero_ft();
    s_partial();
    s_offset(1'b1);
    s_offset(1'b0);
    stop_test();
  end

  // A hang ends the run as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    stop_test();
  end
endmodule
`default_nettype wire

// file: bench/fcr_peer.sv
// Writer and reader logic that drives the FIFO strobes for the bench
`timescale 1ns/100ps
`default_nettype none
`include "fcr_defines.svh"

module fcr_peer (
  // Clock
  input  wire logic                   i_clk,
  // Requests from the bench
  input  wire logic                   i_wr_go,
  input  wire logic [`FCR_WORD_W-1:0] i_wr_word,
  input  wire logic                   i_rd_go,
  input  wire logic                   i_rt_go,
  // Strobes towards the FIFO
  output logic                        o_write_en_b,
  output logic      [`FCR_WORD_W-1:0] o_write_data,
  output logic                        o_read_en_b,
  output logic                        o_reread_b
);
  logic [`FCR_WORD_W-1:0] last_reg;

  // Idle bus shows the inverse of the last word, so a stale capture cannot pass
  always_ff @(posedge i_clk) begin
    if (i_wr_go) begin
      last_reg <= i_wr_word;
    end
  end

  assign o_write_en_b = ~i_wr_go;
  assign o_write_data = i_wr_go ? i_wr_word : ~last_reg;
  assign o_read_en_b  = ~i_rd_go;
  assign o_reread_b   = ~i_rt_go;
endmodule
`default_nettype wire

// file: core/fcr_clear_sync.sv
// Clear synchroniser: asserts at once, releases on the second clock edge
`timescale 1ns/100ps
`default_nettype none

module fcr_clear_sync (
  // Clock and system reset
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  // Clear pin and released clear
  input  wire logic i_clear_b,
  output logic      o_clear_b
);

  logic stage1_reg;
  logic stage2_reg;

  always_ff @(posedge i_clk or negedge i_clear_b) begin
    if (!i_clear_b) begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
    end else if (!i_rst_b) begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
    end else begin
      stage1_reg <= 1'b1;
      stage2_reg <= stage1_reg;
    end
  end

  assign o_clear_b = stage2_reg;

endmodule

`default_nettype wire

// file: core/fcr_core.sv
// Clear, retransmit and reset-time mode control of the FIFO
//
// Notes on behaviour
// - Flag timing select caught during full clear.
// - Partial clear zeroes pointers and output register.
// - Partial clear keeps modes, widths, offsets, method.
// - Read data uses eighteen or nine bits.
// - Read enable reads data word or offset.
// - Retransmit latency select caught during full clear.
// - Reread zeroes read pointer, flags show empty, unless zero latency loads word zero.
// - Serial enable shifts one offset bit.
// - Write enable stores word or parallel offset.
// - Full clear zeroes pointers, sets flag levels.
// - Mode high selects fall-through, ready flags.
// - Mode low selects standard, empty/full flags.
// - Configuration latched only during full clear or system reset.
// - Full clear zeroes the read data register.
// - Both clears act without waiting for clocks.
// - Partial clear keeps mode, sets its flags.
// - Offset access enable steers to offset registers.
// - Mode pin doubles as serial offset input.
`timescale 1ns/100ps
`default_nettype none
`include "fcr_defines.svh"

module fcr_core
  import fcr_pkg::*;
(
  // Clock and reset
  input  wire logic                    I_MCLK,
  input  wire logic                    I_RST_B,
  // Clear pins
  input  wire logic                    I_FULL_CLEAR_B,
  input  wire logic                    I_PARTIAL_CLEAR_B,
  // Configuration and serial data
  input  wire logic                    I_MODE_SELECT_SERIAL_IN,
  input  wire logic                    I_FLAG_TIMING_SELECT,
  input  wire logic                    I_RETRANSMIT_LATENCY_SELECT,
  input  wire logic                    I_READ_PORT_WIDTH,
  input  wire logic                    I_WRITE_PORT_WIDTH,
  input  wire logic                    I_BYTE_ORDER_SELECT,
  input  wire logic                    I_PARITY_INTERLEAVE_SELECT,
  input  wire logic                    I_OFFSET_ACCESS_ENABLE_B,
  // Write side
  input  wire logic                    I_WRITE_EN_B,
  input  wire logic [`FCR_WORD_W-1:0]  I_WRITE_DATA,
  input  wire logic                    I_SERIAL_LOAD_ENABLE_B,
  // Read side
  input  wire logic                    I_READ_EN_B,
  input  wire logic                    I_REREAD_REQUEST_B,
  output logic      [`FCR_WORD_W-1:0]  O_READ_DATA_OUT,
  // Flags
  output logic                         O_EMPTY_FLAG_OR_B,
  output logic                         O_FULL_FLAG_IR_B,
  output logic                         O_ALMOST_EMPTY_FLAG_B,
  output logic                         O_ALMOST_FULL_FLAG_B,
  output logic                         O_HALF_FULL_FLAG_B,
  // Latched configuration
  output logic                         O_FALL_THROUGH_MODE,
  output logic                         O_SERIAL_PROGRAM,
  output logic                         O_SYNC_FLAG_TIMING,
  output logic                         O_ZERO_LATENCY,
  output logic                         O_READ_WIDTH_NARROW,
  output logic                         O_WRITE_WIDTH_NARROW,
  output logic                         O_BYTE_ORDER,
  output logic                         O_PARITY_INTERLEAVE
);

  // ********************************
  // Declarations
  // ********************************
  logic                    full_b;
  logic                    part_b;
  logic                    any_b;
  logic                    fall_through_mode_reg;
  logic                    serial_reg;
  logic                    sync_flag_reg;
  logic                    zero_lat_reg;
  logic                    rd_narrow_reg;
  logic                    wr_narrow_reg;
  logic                    byte_order_reg;
  logic                    parity_reg;
  logic [7:0]              cfg_s1_reg;
  logic [7:0]              cfg_s2_reg;
  logic [`FCR_PTR_W-1:0]   empty_off_reg;
  logic [`FCR_PTR_W-1:0]   full_off_reg;
  logic                    wr_sel_reg;
  logic                    rd_sel_reg;
  logic [`FCR_PTR_W-1:0]   wr_ptr_reg;
  logic [`FCR_PTR_W-1:0]   rd_ptr_reg;
  logic [`FCR_PTR_W-1:0]   rd_ptr_next;
  logic                    out_valid_reg;
  logic                    out_valid_next;
  fcr_rd_state_t           rd_state_reg;
  fcr_rd_state_t           rd_state_next;
  logic [`FCR_PTR_W-1:0]   count;
  logic [`FCR_PTR_W-1:0]   free;
  logic [`FCR_PTR_W-1:0]   empty_lim;
  logic                    is_empty;
  logic                    is_full;
  logic                    reread;
  logic                    data_wr;
  logic                    par_wr;
  logic                    ser_shift;
  logic                    off_rd;
  logic                    mem_rd;
  logic [`FCR_ADDR_W-1:0]  mem_addr;
  logic                    ae_now;
  logic                    af_now;
  logic                    hf_now;
  logic                    ae_reg;
  logic                    af_reg;
  logic                    hf_reg;

  function automatic logic fcr_at_most(input logic [`FCR_PTR_W-1:0] val,
                                       input logic [`FCR_PTR_W-1:0] lim);
    fcr_at_most = (val <= lim);
  endfunction

  // ********************************
  // Clear release
  // ********************************
  fcr_clear_sync u_full_sync (
    .i_clk     (I_MCLK),
    .i_rst_b   (I_RST_B),
    .i_clear_b (I_FULL_CLEAR_B),
    .o_clear_b (full_b)
  );

  fcr_clear_sync u_part_sync (
    .i_clk     (I_MCLK),
    .i_rst_b   (I_RST_B),
    .i_clear_b (I_PARTIAL_CLEAR_B),
    .o_clear_b (part_b)
  );

  assign any_b = full_b & part_b;

  // ********************************
  // Configuration latched while full clear is held
  // ********************************
  // Setting pins pass two flops, matching the two-edge late release of the clear
  // Latching the pins at once would catch values changed after the clear pin rose
  always_ff @(posedge I_MCLK) begin
    cfg_s1_reg <= {I_MODE_SELECT_SERIAL_IN, I_OFFSET_ACCESS_ENABLE_B, I_FLAG_TIMING_SELECT,
                   I_RETRANSMIT_LATENCY_SELECT, I_READ_PORT_WIDTH, I_WRITE_PORT_WIDTH,
                   I_BYTE_ORDER_SELECT, I_PARITY_INTERLEAVE_SELECT};
    cfg_s2_reg <= cfg_s1_reg;
  end

  // A partial clear never reaches these, so every setting survives it
  always_ff @(posedge I_MCLK) begin
    if (!full_b) begin
      fall_through_mode_reg       <= cfg_s2_reg[7];
      serial_reg     <= cfg_s2_reg[6];
      sync_flag_reg  <= cfg_s2_reg[5];
      zero_lat_reg   <= ~cfg_s2_reg[4];
      rd_narrow_reg  <= cfg_s2_reg[3];
      wr_narrow_reg  <= cfg_s2_reg[2];
      byte_order_reg <= cfg_s2_reg[1];
      parity_reg     <= cfg_s2_reg[0];
    end
  end

  // ********************************
  // Offset registers
  // ********************************
  assign ser_shift = full_b && serial_reg && !I_SERIAL_LOAD_ENABLE_B;
  assign par_wr    = full_b && !serial_reg && !I_WRITE_EN_B && !I_OFFSET_ACCESS_ENABLE_B;
  assign off_rd    = full_b && !I_READ_EN_B && !I_OFFSET_ACCESS_ENABLE_B;

  // Serial chain runs in at the empty offset low bit, out of the full offset top
  always_ff @(posedge I_MCLK) begin
    if (!full_b) begin
      empty_off_reg <= `FCR_EMPTY_OFF_RST;
      full_off_reg  <= `FCR_FULL_OFF_RST;
    end else if (ser_shift) begin
      {full_off_reg, empty_off_reg} <= {full_off_reg[`FCR_PTR_W-2:0], empty_off_reg, I_MODE_SELECT_SERIAL_IN};
    end else if (par_wr) begin
      if (!wr_sel_reg) begin
        empty_off_reg <= I_WRITE_DATA[`FCR_PTR_W-1:0];
      end else begin
        full_off_reg <= I_WRITE_DATA[`FCR_PTR_W-1:0];
      end
    end
  end

  // Alternating selectors: empty offset first, then full offset
  always_ff @(posedge I_MCLK) begin
    if (!full_b) begin
      wr_sel_reg <= 1'b0;
      rd_sel_reg <= 1'b0;
    end else begin
      if (par_wr) begin
        wr_sel_reg <= ~wr_sel_reg;
      end
      if (off_rd) begin
        rd_sel_reg <= ~rd_sel_reg;
      end
    end
  end

  // ********************************
  // Occupancy
  // ********************************
  assign count    = wr_ptr_reg - rd_ptr_reg;
  assign free     = `FCR_DEPTH - count;
  assign is_empty = (count == `FCR_PTR_RST);
  assign is_full  = (count == `FCR_DEPTH);
  assign reread   = !I_REREAD_REQUEST_B;

  // Writes into a full store are dropped; the writer must honour the full flag
  assign data_wr = !I_WRITE_EN_B && I_OFFSET_ACCESS_ENABLE_B && !is_full;

  // ********************************
  // Write pointer
  // ********************************
  always_ff @(posedge I_MCLK or negedge any_b) begin
    if (!any_b) begin
      wr_ptr_reg <= `FCR_PTR_RST;
    end else if (data_wr) begin
      wr_ptr_reg <= wr_ptr_reg + `FCR_PTR_ONE;
    end
  end

  // ********************************
  // Read sequencing
  // ********************************
  always_comb begin
    rd_ptr_next    = rd_ptr_reg;
    out_valid_next = out_valid_reg;
    rd_state_next  = FCR_RD_RUN;
    mem_rd         = 1'b0;
    mem_addr       = rd_ptr_reg[`FCR_ADDR_W-1:0];
    if (reread) begin
      rd_ptr_next    = `FCR_PTR_RST;
      out_valid_next = 1'b0;
      // Zero latency puts the first word out on the requesting edge
      if (zero_lat_reg && (wr_ptr_reg != `FCR_PTR_RST)) begin
        mem_rd         = 1'b1;
        mem_addr       = {`FCR_ADDR_W{1'b0}};
        rd_ptr_next    = `FCR_PTR_ONE;
        out_valid_next = fall_through_mode_reg;
      end else begin
        rd_state_next = FCR_RD_SETUP;
      end
    end else if ((rd_state_reg == FCR_RD_RUN) && I_OFFSET_ACCESS_ENABLE_B && !is_empty) begin
      if (fall_through_mode_reg) begin
        if (!out_valid_reg || !I_READ_EN_B) begin
          mem_rd         = 1'b1;
          rd_ptr_next    = rd_ptr_reg + `FCR_PTR_ONE;
          out_valid_next = 1'b1;
        end
      end else if (!I_READ_EN_B) begin
        mem_rd      = 1'b1;
        rd_ptr_next = rd_ptr_reg + `FCR_PTR_ONE;
      end
    end else if (fall_through_mode_reg && !I_READ_EN_B && I_OFFSET_ACCESS_ENABLE_B) begin
      out_valid_next = 1'b0;
    end
  end

  always_ff @(posedge I_MCLK or negedge any_b) begin
    if (!any_b) begin
      rd_ptr_reg <= `FCR_PTR_RST;
    end else begin
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  always_ff @(posedge I_MCLK or negedge any_b) begin
    if (!any_b) begin
      out_valid_reg <= 1'b0;
      rd_state_reg  <= FCR_RD_RUN;
    end else begin
      out_valid_reg <= out_valid_next;
      rd_state_reg  <= rd_state_next;
    end
  end

  // ********************************
  // Storage and read data register
  // ********************************
  fcr_store u_store (
    .i_clk      (I_MCLK),
    .i_clr_b    (any_b),
    .i_wr_en    (data_wr),
    .i_wr_addr  (wr_ptr_reg[`FCR_ADDR_W-1:0]),
    .i_wr_data  (I_WRITE_DATA),
    .i_rd_en    (mem_rd),
    .i_rd_addr  (mem_addr),
    .i_alt_en   (off_rd),
    .i_alt_data (rd_sel_reg ? full_off_reg : empty_off_reg),
    .i_wide     (~rd_narrow_reg),
    .o_rd_data  (O_READ_DATA_OUT)
  );

  // ********************************
  // Flags
  // ********************************
  // Fall-through counts the word parked at the outputs as one more
  assign empty_lim = empty_off_reg + {{(`FCR_PTR_W-1){1'b0}}, fall_through_mode_reg};
  assign ae_now    = !fcr_at_most(count, empty_lim);
  assign af_now    = !fcr_at_most(free, full_off_reg);
  assign hf_now    = fcr_at_most(count, `FCR_HALF);

  always_ff @(posedge I_MCLK or negedge any_b) begin
    if (!any_b) begin
      ae_reg <= 1'b0;
      af_reg <= 1'b1;
      hf_reg <= 1'b1;
    end else begin
      ae_reg <= ae_now;
      af_reg <= af_now;
      hf_reg <= hf_now;
    end
  end

  // Asynchronous timing follows occupancy at once, synchronous waits an edge; half full always waits an edge
  assign O_ALMOST_EMPTY_FLAG_B = sync_flag_reg ? ae_reg : ae_now;
  assign O_ALMOST_FULL_FLAG_B  = sync_flag_reg ? af_reg : af_now;
  assign O_HALF_FULL_FLAG_B    = hf_reg;

  // Output ready high means not ready; input ready low means room
  assign O_EMPTY_FLAG_OR_B = fall_through_mode_reg ? !out_valid_reg
                                      : (!is_empty && (rd_state_reg == FCR_RD_RUN));
  assign O_FULL_FLAG_IR_B  = fall_through_mode_reg ? is_full : !is_full;

  // ********************************
  // Configuration status
  // ********************************
  assign O_FALL_THROUGH_MODE  = fall_through_mode_reg;
  assign O_SERIAL_PROGRAM     = serial_reg;
  assign O_SYNC_FLAG_TIMING   = sync_flag_reg;
  assign O_ZERO_LATENCY       = zero_lat_reg;
  assign O_READ_WIDTH_NARROW  = rd_narrow_reg;
  assign O_WRITE_WIDTH_NARROW = wr_narrow_reg;
  assign O_BYTE_ORDER         = byte_order_reg;
  assign O_PARITY_INTERLEAVE  = parity_reg;

endmodule

`default_nettype wire

// file: core/fcr_defines.svh
// Constants for the clear, retransmit and mode logic of the FIFO
`ifndef FCR_DEFINES_SVH
`define FCR_DEFINES_SVH

// ********************************
// Storage geometry
// ********************************
`define FCR_ADDR_W        6
`define FCR_PTR_W         7
`define FCR_DEPTH         7'h40
`define FCR_HALF          7'h20
`define FCR_WORD_W        18
`define FCR_NARROW_W      9

// ********************************
// Reset values
// ********************************
`define FCR_EMPTY_OFF_RST 7'h07
`define FCR_FULL_OFF_RST  7'h07
`define FCR_PTR_RST       7'h00
`define FCR_PTR_ONE       7'h01
`define FCR_DATA_RST      18'h0_0000

`endif

// file: core/fcr_pkg.sv
// Types shared by the clear, retransmit and mode logic of the FIFO
package fcr_pkg;

  // ********************************
  // Read side sequencing
  // ********************************
  typedef enum logic [1:0] {
    FCR_RD_RUN   = 2'b01,
    FCR_RD_SETUP = 2'b10
  } fcr_rd_state_t;

endpackage

// file: core/fcr_store.sv
// Data storage with its output register
`timescale 1ns/100ps
`default_nettype none
`include "fcr_defines.svh"

module fcr_store (
  // Clock and clear
  input  wire logic                        i_clk,
  input  wire logic                        i_clr_b,
  // Write port
  input  wire logic                        i_wr_en,
  input  wire logic [`FCR_ADDR_W-1:0]      i_wr_addr,
  input  wire logic [`FCR_WORD_W-1:0]      i_wr_data,
  // Read port
  input  wire logic                        i_rd_en,
  input  wire logic [`FCR_ADDR_W-1:0]      i_rd_addr,
  input  wire logic                        i_alt_en,
  input  wire logic [`FCR_PTR_W-1:0]       i_alt_data,
  input  wire logic                        i_wide,
  output logic      [`FCR_WORD_W-1:0]      o_rd_data
);

  logic [`FCR_WORD_W-1:0] mem [0:`FCR_DEPTH-1];
  logic [`FCR_WORD_W-1:0] word;

  always_ff @(posedge i_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  assign word = mem[i_rd_addr];

  // Upper lane stays zero on a narrow read port
  always_ff @(posedge i_clk or negedge i_clr_b) begin
    if (!i_clr_b) begin
      o_rd_data <= `FCR_DATA_RST;
    end else if (i_rd_en) begin
      o_rd_data <= {word[`FCR_WORD_W-1:`FCR_NARROW_W] & {`FCR_NARROW_W{i_wide}}, word[`FCR_NARROW_W-1:0]};
    end else if (i_alt_en) begin
      o_rd_data <= {{(`FCR_WORD_W-`FCR_PTR_W){1'b0}}, i_alt_data};
    end
  end

endmodule

`default_nettype wire
